// ==== cpu_clk_pkg.sv ====
// Constants and types shared by the CPU clock generator control
// Function
// (R1) Reset loads CPU clock control with 02h
// (R2) Main oscillator runs while stop bit clear
// (R3) Software stops main only on subclock
// (R4) Select and divide bits choose CPU clock
// (R5) Instruction takes two CPU clock periods
// (R6) Software writes zero to unused control bits
// (R7) Bit and byte writes both accepted
// (R8) Reset clears suboscillator mode register
// (R9) Subsystem oscillator runs while stop bit clear
// (R10) Feedback resistor connected while bit clear
// (R11) Drop resistor only without subclock use
// (R12) Reset clears source control, main selected
// (R13) Status bit shows subsystem clock running
// (R14) Source select bit picks oscillator
// (R15) Stop instruction halts main oscillator
// (R16) Status bit read-only, others written zero
// (R17) Old clock runs until instruction boundary
// (R18) Select 0 main divided, 1 subsystem
// (R19) Main stop refused while main runs CPU
// (R20) Changeover without runt clock pulses
package cpu_clk_pkg;

  // Register byte addresses
  localparam logic [15:0] SUB_OSC_MODE_ADDR  = 16'hfff0;
  localparam logic [15:0] CLK_SRC_CTRL_ADDR  = 16'hfff2;
  localparam logic [15:0] CPU_CLK_CTRL_ADDR  = 16'hfffb;

  // Reset values
  localparam logic [7:0]  CPU_CLK_CTRL_RST   = 8'h02;
  localparam logic [7:0]  SUB_OSC_MODE_RST   = 8'h00;
  localparam logic [7:0]  CLK_SRC_CTRL_RST   = 8'h00;

  // Field positions
  localparam int          MAIN_OSC_STOP_BIT  = 7;
  localparam int          DIVIDE_SEL_BIT     = 1;
  localparam int          SUB_OSC_STOP_BIT   = 0;
  localparam int          FEEDBACK_OFF_BIT   = 1;
  localparam int          SRC_SELECT_BIT     = 4;
  localparam int          SRC_STATUS_BIT     = 5;

  // Bits that software may change
  localparam logic [7:0]  CPU_CLK_CTRL_WMASK = 8'h82;
  localparam logic [7:0]  SUB_OSC_MODE_WMASK = 8'h03;
  localparam logic [7:0]  CLK_SRC_CTRL_WMASK = 8'h10;

  // Division ratios in oscillator ticks
  localparam logic [2:0]  MAIN_UNDIV_RATIO   = 3'h1;
  localparam logic [2:0]  MAIN_DIV_RATIO     = 3'h4;
  localparam logic [2:0]  SUB_DIV_RATIO      = 3'h2;

  // CPU clocks per minimum instruction, as last count value
  localparam logic [0:0]  INSTR_LAST         = 1'h1;

  // Register port request
  typedef struct packed {
    logic [15:0] addr;
    logic [7:0]  wdata;
    logic [7:0]  wmask;
    logic        wr;
    logic        rd;
  } reg_req_t;

  // Oscillator control outputs
  typedef struct packed {
    logic main_en;
    logic sub_en;
    logic feedback_en;
  } osc_ctrl_t;

  // CPU clock selection
  typedef struct packed {
    logic src;
    logic div;
  } clk_sel_t;

  typedef enum logic {SW_IDLE, SW_PENDING} switch_state_t;

endpackage

// ==== clk_tick_div.sv ====
// Tick divider that passes every Nth oscillator tick
`timescale 1ns/1ps
`default_nettype none

module clk_tick_div (
  input  wire logic       i_clk,
  input  wire logic       i_rst,
  input  wire logic       i_tick,
  input  wire logic       i_clear,
  input  wire logic [2:0] i_ratio,
  output logic            o_tick
);

  logic [2:0] cnt_q;
  logic       last;

  // Last tick of a period; ratio 1 passes every tick
  assign last = (cnt_q >= (i_ratio - 3'h1));

  // Tick counter, cleared at a source changeover
  always_ff @(posedge i_clk) begin
    if (i_rst || i_clear) begin
      cnt_q <= 3'h0;
    end else if (i_tick) begin
      cnt_q <= last ? 3'h0 : cnt_q + 3'h1;
    end
  end

  // Divided tick, one cycle wide
  always_ff @(posedge i_clk) begin
    if (i_rst || i_clear) begin
      o_tick <= 1'b0;
    end else begin
      o_tick <= i_tick && last;
    end
  end

endmodule

`default_nettype wire

// ==== cpu_clock_generator_control.sv ====
// CPU clock generator control: registers, source switch, oscillator enables
`timescale 1ns/1ps
`default_nettype none

module cpu_clock_generator_control
  import cpu_clk_pkg::*;
(
  input  wire logic      I_CLK,
  input  wire logic      I_RST,
  input  wire reg_req_t  I_REQ,
  input  wire logic      I_MAIN_TICK,
  input  wire logic      I_SUB_TICK,
  input  wire logic      I_STOP_EXEC,
  input  wire logic      I_WAKE,
  output logic [7:0]     O_RDATA,
  output logic           O_CPU_TICK,
  output logic           O_INSTR_TICK,
  output osc_ctrl_t      O_OSC,
  output logic           O_CLK_STATUS
);

  ////////////////////////////////////////////////////////////////////////////
  // Helpers

  // Address hit for a strobe
  function automatic logic is_hit(input reg_req_t req, input logic [15:0] addr);
    is_hit = (req.addr == addr);
  endfunction

  // Bit-masked merge limited to writable bits
  function automatic logic [7:0] merge(input logic [7:0] old,
                                       input reg_req_t   req,
                                       input logic [7:0] allowed);
    logic [7:0] m;
    m     = req.wmask & allowed;
    merge = (old & ~m) | (req.wdata & m);
  endfunction

  ////////////////////////////////////////////////////////////////////////////
  // Declarations

  logic [7:0]    cpu_ctrl_q;
  logic [7:0]    sub_mode_q;
  logic [7:0]    src_ctrl_q;
  logic [7:0]    cpu_ctrl_d;
  logic          stop_mode_q;
  clk_sel_t      active_q;
  clk_sel_t      target;
  switch_state_t sw_state_q;
  logic [0:0]    instr_cnt_q;
  logic          main_stop;
  logic          main_div_tick;
  logic          sub_div_tick;
  logic          src_tick;
  logic          boundary;
  logic          switch_ok;
  logic          switch_now;
  logic [2:0]    main_ratio;
  logic [7:0]    rdata_d;

  ////////////////////////////////////////////////////////////////////////////
  // Registers

  // CPU clock control next value with refused main stop
  always_comb begin
    cpu_ctrl_d = merge(cpu_ctrl_q, I_REQ, CPU_CLK_CTRL_WMASK); // see (R7)
    if (!active_q.src && !cpu_ctrl_q[MAIN_OSC_STOP_BIT]) begin
      cpu_ctrl_d[MAIN_OSC_STOP_BIT] = 1'b0; // see (R19)
    end
  end

  // CPU clock control register
  always_ff @(posedge I_CLK) begin
    if (I_RST) begin
      cpu_ctrl_q <= CPU_CLK_CTRL_RST; // see (R1)
    end else if (I_REQ.wr && is_hit(I_REQ, CPU_CLK_CTRL_ADDR)) begin
      cpu_ctrl_q <= cpu_ctrl_d;
    end
  end

  // Suboscillator mode register
  always_ff @(posedge I_CLK) begin
    if (I_RST) begin
      sub_mode_q <= SUB_OSC_MODE_RST; // see (R8)
    end else if (I_REQ.wr && is_hit(I_REQ, SUB_OSC_MODE_ADDR)) begin
      sub_mode_q <= merge(sub_mode_q, I_REQ, SUB_OSC_MODE_WMASK); // see (R7)
    end
  end

  // Source control register, status bit excluded
  always_ff @(posedge I_CLK) begin
    if (I_RST) begin
      src_ctrl_q <= CLK_SRC_CTRL_RST; // see (R12)
    end else if (I_REQ.wr && is_hit(I_REQ, CLK_SRC_CTRL_ADDR)) begin
      src_ctrl_q <= merge(src_ctrl_q, I_REQ, CLK_SRC_CTRL_WMASK); // see (R16)
    end
  end

  // Read mux, status bit from running source
  always_comb begin
    rdata_d = 8'h00;
    if (is_hit(I_REQ, CPU_CLK_CTRL_ADDR)) begin
      rdata_d = cpu_ctrl_q;
    end else if (is_hit(I_REQ, SUB_OSC_MODE_ADDR)) begin
      rdata_d = sub_mode_q;
    end else if (is_hit(I_REQ, CLK_SRC_CTRL_ADDR)) begin
      rdata_d = src_ctrl_q;
      rdata_d[SRC_STATUS_BIT] = active_q.src; // see (R13)
    end
  end

  // Read data valid one cycle after the strobe only
  always_ff @(posedge I_CLK) begin
    if (I_RST) begin
      O_RDATA <= 8'h00;
    end else begin
      O_RDATA <= I_REQ.rd ? rdata_d : 8'h00;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Oscillator control

  // Stop instruction state, held until wake
  always_ff @(posedge I_CLK) begin
    if (I_RST) begin
      stop_mode_q <= 1'b0;
    end else if (I_STOP_EXEC) begin
      stop_mode_q <= 1'b1; // see (R15)
    end else if (I_WAKE) begin
      stop_mode_q <= 1'b0;
    end
  end

  assign main_stop = cpu_ctrl_q[MAIN_OSC_STOP_BIT] || stop_mode_q; // see (R2)

  // Oscillator enables, all off while reset is held
  always_ff @(posedge I_CLK) begin
    if (I_RST) begin
      O_OSC <= '0;
    end else begin
      O_OSC.main_en     <= !main_stop; // see (R2)
      O_OSC.sub_en      <= !sub_mode_q[SUB_OSC_STOP_BIT]; // see (R9)
      O_OSC.feedback_en <= !sub_mode_q[FEEDBACK_OFF_BIT]; // see (R10)
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Clock dividers

  // Requested selection from the two registers
  assign target.src = src_ctrl_q[SRC_SELECT_BIT]; // see (R14)
  assign target.div = cpu_ctrl_q[DIVIDE_SEL_BIT];

  // Main ratio follows the active divide bit
  assign main_ratio = active_q.div ? MAIN_DIV_RATIO : MAIN_UNDIV_RATIO; // see (R4)

  clk_tick_div u_main_div (
    .i_clk   (I_CLK),
    .i_rst   (I_RST),
    .i_tick  (I_MAIN_TICK && O_OSC.main_en),
    .i_clear (switch_now),
    .i_ratio (main_ratio),
    .o_tick  (main_div_tick)
  );

  clk_tick_div u_sub_div (
    .i_clk   (I_CLK),
    .i_rst   (I_RST),
    .i_tick  (I_SUB_TICK && O_OSC.sub_en),
    .i_clear (switch_now),
    .i_ratio (SUB_DIV_RATIO),
    .o_tick  (sub_div_tick)
  );

  // Active source picks the divided tick
  assign src_tick = active_q.src ? sub_div_tick : main_div_tick; // see (R18)

  ////////////////////////////////////////////////////////////////////////////
  // CPU clock and instruction timing

  // CPU clock tick
  always_ff @(posedge I_CLK) begin
    if (I_RST) begin
      O_CPU_TICK <= 1'b0;
    end else begin
      O_CPU_TICK <= src_tick; // see (R4)
    end
  end

  // Counts CPU clocks inside an instruction
  always_ff @(posedge I_CLK) begin
    if (I_RST) begin
      instr_cnt_q <= 1'h0;
    end else if (src_tick) begin
      instr_cnt_q <= (instr_cnt_q == INSTR_LAST) ? 1'h0 : instr_cnt_q + 1'h1; // see (R5)
    end
  end

  // End of a minimum instruction on the old clock
  assign boundary = src_tick && (instr_cnt_q == INSTR_LAST);

  // Instruction boundary tick
  always_ff @(posedge I_CLK) begin
    if (I_RST) begin
      O_INSTR_TICK <= 1'b0;
    end else begin
      O_INSTR_TICK <= boundary; // see (R5)
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Source changeover

  // A return to main waits until its oscillator is allowed to run
  assign switch_ok  = target.src || !main_stop; // see (R19)
  assign switch_now = (sw_state_q == SW_PENDING) && boundary && switch_ok; // see (R17)

  // Pending switch waits for the old clock's instruction end
  always_ff @(posedge I_CLK) begin
    if (I_RST) begin
      sw_state_q <= SW_IDLE;
    end else begin
      case (sw_state_q)
        SW_IDLE: begin
          if (target != active_q) begin
            sw_state_q <= SW_PENDING;
          end
        end
        SW_PENDING: begin
          if (switch_now || (target == active_q)) begin
            sw_state_q <= SW_IDLE;
          end
        end
        default: begin
          sw_state_q <= SW_IDLE;
        end
      endcase
    end
  end

  // Active selection changes only on an old clock tick
  always_ff @(posedge I_CLK) begin
    if (I_RST) begin
      active_q <= '{src: 1'b0, div: CPU_CLK_CTRL_RST[DIVIDE_SEL_BIT]}; // see (R1)
    end else if (switch_now) begin
      active_q <= target; // see (R20)
    end
  end

  // Status output follows the running source
  always_ff @(posedge I_CLK) begin
    if (I_RST) begin
      O_CLK_STATUS <= 1'b0; // see (R12)
    end else begin
      O_CLK_STATUS <= active_q.src; // see (R13)
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Assertions

  property p_reset_values;
    @(posedge I_CLK) disable iff (I_RST)
    $fell(I_RST) |-> (cpu_ctrl_q == 8'h02) && (sub_mode_q == 8'h00)
                     && (src_ctrl_q == 8'h00) && !active_q.src && active_q.div;
  endproperty
  a_reset_values: assert property (p_reset_values) // see (R1)
    else $error("reset values wrong");

  property p_main_stop_off;
    @(posedge I_CLK) disable iff (I_RST)
    cpu_ctrl_q[7] |=> !O_OSC.main_en;
  endproperty
  a_main_stop_off: assert property (p_main_stop_off) // see (R2)
    else $error("main oscillator runs while stopped");

  property p_sub_osc;
    @(posedge I_CLK) disable iff (I_RST)
    !$past(I_RST) |-> (O_OSC.sub_en == !$past(sub_mode_q[0]))
                      && (O_OSC.feedback_en == !$past(sub_mode_q[1]));
  endproperty
  a_sub_osc: assert property (p_sub_osc) // see (R9)
    else $error("subsystem oscillator control wrong");

  property p_stop_exec;
    @(posedge I_CLK) disable iff (I_RST)
    I_STOP_EXEC |=> ##1 !O_OSC.main_en;
  endproperty
  a_stop_exec: assert property (p_stop_exec) // see (R15)
    else $error("stop instruction left main running");

  property p_no_main_stop;
    @(posedge I_CLK) disable iff (I_RST)
    (!active_q.src && !cpu_ctrl_q[7]) |=> !cpu_ctrl_q[7];
  endproperty
  a_no_main_stop: assert property (p_no_main_stop) // see (R19)
    else $error("main stop accepted on main clock");

  property p_status;
    @(posedge I_CLK) disable iff (I_RST)
    $changed(active_q.src) |-> ##1 (O_CLK_STATUS == active_q.src);
  endproperty
  a_status: assert property (p_status) // see (R13)
    else $error("status bit does not follow source");

  property p_src_tick;
    @(posedge I_CLK) disable iff (I_RST)
    ((active_q.src && sub_div_tick) || (!active_q.src && main_div_tick))
      |=> O_CPU_TICK;
  endproperty
  a_src_tick: assert property (p_src_tick) // see (R4)
    else $error("cpu tick lost from selected source");

  property p_instr_tick;
    @(posedge I_CLK) disable iff (I_RST)
    O_INSTR_TICK |-> O_CPU_TICK && (instr_cnt_q == 1'h0);
  endproperty
  a_instr_tick: assert property (p_instr_tick) // see (R5)
    else $error("instruction tick off clock boundary");

  property p_glitch_free;
    @(posedge I_CLK) disable iff (I_RST)
    $changed(active_q) |-> $past(src_tick) && ($past(instr_cnt_q) == INSTR_LAST);
  endproperty
  a_glitch_free: assert property (p_glitch_free) // see (R20)
    else $error("source changed off an instruction boundary");

  // Main oscillator enabled one cycle after its stop causes clear
  property p_main_run;
    @(posedge I_CLK) disable iff (I_RST)
    (!I_RST && !cpu_ctrl_q[7] && !stop_mode_q) |=> O_OSC.main_en;
  endproperty
  a_main_run: assert property (p_main_run) // see (R2)
    else $error("main oscillator held off while enabled");

  // Return to a stopped main oscillator stays pending
  property p_main_hold;
    @(posedge I_CLK) disable iff (I_RST)
    (active_q.src && !target.src && main_stop) |=> active_q.src;
  endproperty
  a_main_hold: assert property (p_main_hold) // see (R19)
    else $error("switched to a stopped main oscillator");

  // No CPU tick without a tick from the active source
  property p_cpu_tick_src;
    @(posedge I_CLK) disable iff (I_RST)
    O_CPU_TICK |-> $past(src_tick);
  endproperty
  a_cpu_tick_src: assert property (p_cpu_tick_src) // see (R4)
    else $error("cpu tick without source tick");

endmodule

`default_nettype wire

// ==== osc_model.sv ====
// Oscillator model producing main and subsystem tick pulses
`timescale 1ns/1ps
`default_nettype none

module osc_model
  import cpu_clk_pkg::*;
#(
  parameter int MAIN_P = 3,
  parameter int SUB_P  = 5
)(
  input  wire logic      i_clk,
  input  wire logic      i_rst,
  input  wire osc_ctrl_t i_osc,
  output logic           o_main_tick,
  output logic           o_sub_tick
);
  int main_cnt;
  int sub_cnt;

  ////////////////////////////////////////////////////////////////////////////////
  // A halted oscillator is silent and restarts its phase
  always_ff @(posedge i_clk) begin
    if (i_rst || i_osc.main_en !== 1'b1) begin
      main_cnt <= 0;
    end else begin
      main_cnt <= (main_cnt == MAIN_P - 1) ? 0 : main_cnt + 1;
    end
  end

  // Subsystem oscillator phase counter
  always_ff @(posedge i_clk) begin
    if (i_rst || i_osc.sub_en !== 1'b1) begin
      sub_cnt <= 0;
    end else begin
      sub_cnt <= (sub_cnt == SUB_P - 1) ? 0 : sub_cnt + 1;
    end
  end

  // One-cycle tick at the end of each oscillator period
  assign o_main_tick = (i_osc.main_en === 1'b1) && (main_cnt == MAIN_P - 1);
  assign o_sub_tick  = (i_osc.sub_en === 1'b1) && (sub_cnt == SUB_P - 1);
endmodule

`default_nettype wire

// ==== tb_top.sv ====
// Self-checking testbench for the CPU clock generator control
`timescale 1ns/1ps
`default_nettype none

module tb_top
  import cpu_clk_pkg::*;
;
  logic      clk;
  logic      rst;
  reg_req_t  req;
  logic      main_tick;
  logic      sub_tick;
  logic      stop_exec;
  logic      wake;
  logic [7:0] rdata;
  logic      cpu_tick;
  logic      instr_tick;
  osc_ctrl_t osc;
  logic      status;
  int        mismatches = 0;
  int        checks_done = 0;

  cpu_clock_generator_control dut (
    .I_CLK(clk), .I_RST(rst), .I_REQ(req), .I_MAIN_TICK(main_tick),
    .I_SUB_TICK(sub_tick), .I_STOP_EXEC(stop_exec), .I_WAKE(wake),
    .O_RDATA(rdata), .O_CPU_TICK(cpu_tick), .O_INSTR_TICK(instr_tick),
    .O_OSC(osc), .O_CLK_STATUS(status)
  );

  osc_model #(.MAIN_P(3), .SUB_P(5)) osc_m (
    .i_clk(clk), .i_rst(rst), .i_osc(osc),
    .o_main_tick(main_tick), .o_sub_tick(sub_tick)
  );

  ////////////////////////////////////////////////////////////////////////////////
  // Clock generation
  initial begin
    clk = 1'b0;
    forever #5 clk = ~clk;
  end

  // Compare and count
  task automatic chk(input logic [7:0] got, input logic [7:0] exp, input string msg);
    checks_done++;
    if (got !== exp) begin
      mismatches++;
      $display("ERROR %0t %s got %h exp %h", $time, msg, got, exp);
    end
  endtask

  // Register bus write and read
  task automatic wr(input logic [15:0] a, input logic [7:0] d, input logic [7:0] m);
    @(posedge clk);
    req <= '{addr: a, wdata: d, wmask: m, wr: 1'b1, rd: 1'b0};
    @(posedge clk);
    req.wr <= 1'b0;
    repeat (2) @(negedge clk);
  endtask

  task automatic rd(input logic [15:0] a, input logic [7:0] e);
    @(posedge clk);
    req <= '{addr: a, wdata: 8'h00, wmask: 8'h00, wr: 1'b0, rd: 1'b1};
    @(posedge clk);
    req.rd <= 1'b0;
    #1 chk(rdata, e, "read data");
  endtask

  function automatic logic tick(input bit ins);
    return ins ? instr_tick : cpu_tick;
  endfunction

  // Cycles between two successive CPU or instruction ticks
  task automatic per(input bit ins, input logic [7:0] e);
    int n;
    @(negedge clk);
    for (n = 0; n < 300 && tick(ins) !== 1'b1; n++) @(negedge clk);
    n = 0;
    do begin
      @(negedge clk);
      n++;
    end while (tick(ins) !== 1'b1 && n < 300);
    chk(8'(n), e, "tick period");
  endtask

  task automatic wait_status(input logic v);
    for (int n = 0; n < 100 && status !== v; n++) @(negedge clk);
    chk({7'h00, status}, {7'h00, v}, "clock status");
  endtask

  ////////////////////////////////////////////////////////////////////////////////
  // Scenarios
  task automatic t_reset();
    rd(CPU_CLK_CTRL_ADDR, 8'h02);
    rd(SUB_OSC_MODE_ADDR, 8'h00);
    rd(CLK_SRC_CTRL_ADDR, 8'h00);
    chk({5'h00, osc}, 8'h07, "osc enables");
    chk({7'h00, status}, 8'h00, "status");
  endtask

  task automatic t_regs();
    rd(16'hffff, 8'h00);
    wr(SUB_OSC_MODE_ADDR, 8'hff, 8'hff);
    rd(SUB_OSC_MODE_ADDR, 8'h03);
    chk({5'h00, osc}, 8'h04, "sub off, resistor off");
    wr(SUB_OSC_MODE_ADDR, 8'h00, 8'h01);
    rd(SUB_OSC_MODE_ADDR, 8'h02);
    chk({5'h00, osc}, 8'h06, "sub on, resistor off");
    wr(SUB_OSC_MODE_ADDR, 8'h00, 8'h02);
    chk({5'h00, osc}, 8'h07, "resistor back on");
    wr(CLK_SRC_CTRL_ADDR, 8'h20, 8'h20);
    rd(CLK_SRC_CTRL_ADDR, 8'h00);
  endtask

  task automatic t_ratio();
    per(1'b0, 8'd12);
    per(1'b1, 8'd24);
    wr(CPU_CLK_CTRL_ADDR, 8'h00, 8'h02);
    repeat (30) @(negedge clk);
    per(1'b0, 8'd3);
    per(1'b1, 8'd6);
    wr(CPU_CLK_CTRL_ADDR, 8'h02, 8'h02);
    repeat (30) @(negedge clk);
    wr(CPU_CLK_CTRL_ADDR, 8'h80, 8'h80);
    rd(CPU_CLK_CTRL_ADDR, 8'h02);
    chk({7'h00, osc.main_en}, 8'h01, "main kept");
  endtask

  task automatic t_sub();
    wr(CLK_SRC_CTRL_ADDR, 8'h10, 8'hff);
    wait_status(1'b1);
    wr(CLK_SRC_CTRL_ADDR, 8'h10, 8'h30);
    rd(CLK_SRC_CTRL_ADDR, 8'h30);
    per(1'b0, 8'd10);
    wr(CPU_CLK_CTRL_ADDR, 8'h80, 8'h80);
    rd(CPU_CLK_CTRL_ADDR, 8'h82);
    chk({7'h00, osc.main_en}, 8'h00, "main stopped");
    per(1'b0, 8'd10);
    wr(CLK_SRC_CTRL_ADDR, 8'h00, 8'hff);
    repeat (40) @(negedge clk);
    chk({7'h00, status}, 8'h01, "held on sub");
    wr(CPU_CLK_CTRL_ADDR, 8'h00, 8'h80);
    wait_status(1'b0);
    per(1'b0, 8'd12);
  endtask

  task automatic t_stop();
    @(posedge clk);
    stop_exec <= 1'b1;
    @(posedge clk);
    stop_exec <= 1'b0;
    repeat (3) @(negedge clk);
    chk({7'h00, osc.main_en}, 8'h00, "stop halts main");
    @(posedge clk);
    wake <= 1'b1;
    @(posedge clk);
    wake <= 1'b0;
    repeat (3) @(negedge clk);
    chk({7'h00, osc.main_en}, 8'h01, "wake restarts");
  endtask

  // Reset in mid-run restores every register
  task automatic t_rerun();
    wr(SUB_OSC_MODE_ADDR, 8'h03, 8'hff);
    wr(CPU_CLK_CTRL_ADDR, 8'h00, 8'h02);
    @(posedge clk);
    rst <= 1'b1;
    repeat (4) @(posedge clk);
    rst <= 1'b0;
    repeat (2) @(negedge clk);
    t_reset();
  endtask

  // Verdict and end of run
  task automatic summarize();
    $display("Checks %0d, mismatches %0d", checks_done, mismatches);
    if (mismatches == 0 && checks_done > 0) begin
      $display("Simulation passed");
    end else begin
      $display("Simulation failed");
    end
    $finish;
  endtask

  // Main sequence
  initial begin
    rst = 1'b1;
    req = '0;
    stop_exec = 1'b0;
    wake = 1'b0;
    repeat (4) @(posedge clk);
    rst <= 1'b0;
    repeat (2) @(negedge clk);
    t_reset();
    t_regs();
    t_ratio();
    t_sub();
    t_stop();
    t_rerun();
    summarize();
  end

  // Watchdog against a hang
  initial begin
    #100us;
    mismatches++;
    summarize();
  end
endmodule

`default_nettype wire
